// >>> hw/lepwm_pkg.sv
// Package: register map, field widths and reset values of the leading-edge PWM block
package lepwm_pkg;
  localparam int CW = 16;                      // Counter and event width
  localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CW-1:0] CNT_ONE  = 16'h0001;
  localparam int AW = 6;                       // AXI address width
  // Register byte addresses
  localparam logic [AW-1:0] A_CTRL   = 6'h00;
  localparam logic [AW-1:0] A_PERIOD = 6'h04;
  localparam logic [AW-1:0] A_EV1    = 6'h08;
  localparam logic [AW-1:0] A_EV2    = 6'h0C;
  localparam logic [AW-1:0] A_EV3    = 6'h10;
  localparam logic [AW-1:0] A_EV4    = 6'h14;
  localparam logic [AW-1:0] A_CADJ   = 6'h18;
  localparam logic [AW-1:0] A_ADS    = 6'h1C;
  localparam logic [AW-1:0] A_PHASE  = 6'h20;
  localparam logic [AW-1:0] A_SMP1   = 6'h24;
  localparam logic [AW-1:0] A_SMP2   = 6'h28;
  localparam logic [AW-1:0] A_BLKAB  = 6'h2C;
  localparam logic [AW-1:0] A_BLKAE  = 6'h30;
  localparam logic [AW-1:0] A_BLKBB  = 6'h34;
  localparam logic [AW-1:0] A_BLKBE  = 6'h38;
  localparam logic [AW-1:0] A_STAT   = 6'h3C;
  // Control fields
  localparam int CTRL_EN  = 0;                 // Counter enable
  localparam int CTRL_MID = 1;                 // 1: mid-pulse adaptive sample
  localparam int CTRL_PHF = 2;                 // 1: phase trigger from filter duty
  localparam logic [CW-1:0] PERIOD_RST = 16'h00FF;
  localparam logic [1:0] RESP_OK     = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lepwm_pkg

// >>> hw/lepwm_match.sv
// Leaf: one compare point that pulses when the counter hits its target
`timescale 1ns/1ps
`default_nettype none
module lepwm_match
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [lepwm_pkg::CW-1:0]  cnt,
  input  wire logic [lepwm_pkg::CW-1:0]  target,
  input  wire logic                      run,
  output var  logic                      hit_r
);
  logic hit_nxt;

  // Registered equality so every event leaves a flip-flop
  always_comb
  begin
    hit_nxt = run && (cnt == target);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hit_r <= 1'b0;
    else
      hit_r <= hit_nxt;
  end
endmodule : lepwm_match
`default_nettype wire

// >>> hw/lepwm_top.sv
// Leading-edge PWM event timing with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module lepwm_top
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [lepwm_pkg::CW-1:0] filter_duty,
  input  wire logic [lepwm_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  output var  logic [1:0]               s_axi_bresp,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [lepwm_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  output var  logic [31:0]              s_axi_rdata,
  output var  logic [1:0]               s_axi_rresp,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output var  logic                     pwm_a_r,
  output var  logic                     pwm_b_r,
  output var  logic                     adapt_trig_r,
  output var  logic                     phase_trig_r,
  output var  logic                     smp1_trig_r,
  output var  logic                     smp2_trig_r,
  output var  logic                     blank_a_r,
  output var  logic                     blank_b_r
);
  localparam int CW = lepwm_pkg::CW;
  localparam int NE = 10;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [2:0]    ctrl_r, ctrl_nxt;
  logic [CW-1:0] regs_r [1:14];
  logic [CW-1:0] regs_nxt [1:14];
  logic          aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [lepwm_pkg::AW-1:0] awa_r, awa_nxt;
  logic [31:0]   wd_r, wd_nxt;
  logic [3:0]    ws_r, ws_nxt;
  logic          bv_r, bv_nxt;
  logic [1:0]    br_r, br_nxt;
  logic          rv_r, rv_nxt;
  logic [1:0]    rr_r, rr_nxt;
  logic [31:0]   rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          awr_r, wr_r, arr_r;

  // Index 1..14 maps offsets 0x04..0x38 in order
  function automatic logic [3:0] idx_of(input logic [lepwm_pkg::AW-1:0] a);
    idx_of = a[5:2];
  endfunction : idx_of

  function automatic logic mapped(input logic [lepwm_pkg::AW-1:0] a);
    mapped = (a[1:0] == 2'h0);
  endfunction : mapped

  // Write path: address and data may come in either order, response after both
  always_comb
  begin
    logic [3:0]  wi;
    logic [31:0] m;
    wi = idx_of(awa_r);
    m = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
    ctrl_nxt = ctrl_r;
    for (int i = 1; i <= 14; i++)
      regs_nxt[i] = regs_r[i];
    aw_got_nxt = aw_got_r || s_axi_awvalid;
    w_got_nxt = w_got_r || s_axi_wvalid;
    awa_nxt = (!aw_got_r && s_axi_awvalid) ? s_axi_awaddr : awa_r;
    wd_nxt = (!w_got_r && s_axi_wvalid) ? s_axi_wdata : wd_r;
    ws_nxt = (!w_got_r && s_axi_wvalid) ? s_axi_wstrb : ws_r;
    bv_nxt = bv_r && !s_axi_bready;
    br_nxt = br_r;
    if (aw_got_r && w_got_r && !bv_r)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = lepwm_pkg::RESP_OK;
      if (!mapped(awa_r) || awa_r == lepwm_pkg::A_STAT)
        br_nxt = lepwm_pkg::RESP_SLVERR;
      else if (awa_r == lepwm_pkg::A_CTRL)
        ctrl_nxt = (ctrl_r & ~m[2:0]) | (wd_r[2:0] & m[2:0]);
      else
        regs_nxt[wi] = (regs_r[wi] & ~m[CW-1:0]) | (wd_r[CW-1:0] & m[CW-1:0]);
    end
  end

  // Read path: one-cycle answer, status shows live counter
  always_comb
  begin
    rv_nxt = rv_r && !s_axi_rready;
    rr_nxt = rr_r;
    rd_nxt = rd_r;
    if (s_axi_arvalid && !rv_r)
    begin
      rv_nxt = 1'b1;
      rr_nxt = lepwm_pkg::RESP_OK;
      rd_nxt = 32'h0000_0000;
      if (!mapped(s_axi_araddr))
        rr_nxt = lepwm_pkg::RESP_SLVERR;
      else if (s_axi_araddr == lepwm_pkg::A_CTRL)
        rd_nxt = {29'h0000_0000, ctrl_r};
      else if (s_axi_araddr == lepwm_pkg::A_STAT)
        rd_nxt = {16'h0000, cnt_r};
      else
        rd_nxt = {16'h0000, regs_r[idx_of(s_axi_araddr)]};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= 3'h0;
      for (int i = 1; i <= 14; i++)
        regs_r[i] <= lepwm_pkg::CNT_ZERO;
      regs_r[1] <= lepwm_pkg::PERIOD_RST;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awa_r <= 6'h00;
      wd_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      bv_r <= 1'b0;
      br_r <= 2'h0;
      rv_r <= 1'b0;
      rr_r <= 2'h0;
      rd_r <= 32'h0000_0000;
      awr_r <= 1'b1;
      wr_r <= 1'b1;
      arr_r <= 1'b1;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      for (int i = 1; i <= 14; i++)
        regs_r[i] <= regs_nxt[i];
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      rv_r <= rv_nxt;
      rr_r <= rr_nxt;
      rd_r <= rd_nxt;
      awr_r <= !aw_got_nxt;
      wr_r <= !w_got_nxt;
      arr_r <= !rv_nxt;
    end
  end

  // Ready flops mirror the not-busy state so every bus output leaves a flip-flop
  assign s_axi_awready = awr_r;
  assign s_axi_wready  = wr_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = arr_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rresp   = rr_r;
  assign s_axi_rdata   = rd_r;

  // ****************************************************************
  // Period counter and edge targets
  // ****************************************************************
  logic run;
  assign run = ctrl_r[lepwm_pkg::CTRL_EN];

  // Counter wraps after the period limit; held at zero while disabled
  always_comb
  begin
    if (!run || cnt_r >= regs_r[1])
      cnt_nxt = lepwm_pkg::CNT_ZERO;
    else
      cnt_nxt = cnt_r + lepwm_pkg::CNT_ONE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= lepwm_pkg::CNT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  // Targets wrap modulo 2^16; software keeps them inside the period
  logic [CW-1:0] a_rise, a_fall, b_rise, b_fall, adapt_t, phase_t;
  always_comb
  begin
    a_fall = regs_r[2];
    a_rise = regs_r[2] - filter_duty + regs_r[6];
    b_rise = regs_r[5];
    b_fall = a_rise - (regs_r[3] - regs_r[4]);
    if (ctrl_r[lepwm_pkg::CTRL_MID])
      adapt_t = regs_r[2] - (filter_duty >> 1) + regs_r[7];
    else
      adapt_t = regs_r[2] - filter_duty + regs_r[7];
    phase_t = ctrl_r[lepwm_pkg::CTRL_PHF] ? filter_duty : regs_r[8];
  end

  // ****************************************************************
  // Compare points, one per event
  // ****************************************************************
  logic [CW-1:0] tgt [NE];
  logic [NE-1:0] hit;
  assign tgt[0] = a_rise;
  assign tgt[1] = a_fall;
  assign tgt[2] = b_rise;
  assign tgt[3] = b_fall;
  assign tgt[4] = adapt_t;
  assign tgt[5] = phase_t;
  assign tgt[6] = regs_r[9];
  assign tgt[7] = regs_r[10];
  assign tgt[8] = regs_r[11];
  assign tgt[9] = regs_r[12];
  logic [1:0] hitx;
  for (genvar g = 0; g < NE; g++)
  begin : g_cmp
    lepwm_match u_m (.aclk(aclk), .aresetn(aresetn), .cnt(cnt_r),
                     .target(tgt[g]), .run(run), .hit_r(hit[g]));
  end
  // Blanking B edges share the same leaf
  lepwm_match u_bb (.aclk(aclk), .aresetn(aresetn), .cnt(cnt_r),
                    .target(regs_r[13]), .run(run), .hit_r(hitx[0]));
  lepwm_match u_be (.aclk(aclk), .aresetn(aresetn), .cnt(cnt_r),
                    .target(regs_r[14]), .run(run), .hit_r(hitx[1]));

  // ****************************************************************
  // Output levels
  // ****************************************************************
  logic a_nxt, b_nxt, ba_nxt, bb_nxt;
  // Set edge wins if both targets coincide; outputs idle low when disabled
  always_comb
  begin
    a_nxt  = run && (hit[0] || (pwm_a_r && !hit[1]));
    b_nxt  = run && (hit[2] || (pwm_b_r && !hit[3]));
    ba_nxt = run && (hit[8] || (blank_a_r && !hit[9]));
    bb_nxt = run && (hitx[0] || (blank_b_r && !hitx[1]));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_a_r <= 1'b0;
      pwm_b_r <= 1'b0;
      blank_a_r <= 1'b0;
      blank_b_r <= 1'b0;
    end
    else
    begin
      pwm_a_r <= a_nxt;
      pwm_b_r <= b_nxt;
      blank_a_r <= ba_nxt;
      blank_b_r <= bb_nxt;
    end
  end
  assign adapt_trig_r = hit[4];
  assign phase_trig_r = hit[5];
  assign smp1_trig_r  = hit[6];
  assign smp2_trig_r  = hit[7];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cnt_wrap: assert property (run && cnt_r >= regs_r[1] |=> cnt_r == lepwm_pkg::CNT_ZERO)
    else $error("counter did not wrap");
  a_a_fall: assert property (run && $stable(run) && cnt_r == a_fall && a_fall != a_rise
    |=> ##1 !pwm_a_r) else $error("output A did not fall");
  a_a_rise: assert property (run && cnt_r == a_rise ##1 run |=> pwm_a_r)
    else $error("output A did not rise");
  a_adapt_end: assert property (run && !ctrl_r[lepwm_pkg::CTRL_MID] && cnt_r == regs_r[2] - filter_duty
    + regs_r[7] |=> adapt_trig_r) else $error("end-pulse sample missed");
  a_adapt_mid: assert property (run && ctrl_r[lepwm_pkg::CTRL_MID]
    && cnt_r == regs_r[2] - (filter_duty >> 1)
    + regs_r[7] |=> adapt_trig_r) else $error("mid-pulse sample missed");
  a_b_rise: assert property (run && cnt_r == regs_r[5] ##1 run |=> pwm_b_r)
    else $error("output B did not rise");
  a_b_fall: assert property (run && cnt_r == b_fall && b_fall != regs_r[5] |=> ##1 !pwm_b_r)
    else $error("output B did not fall");
  a_phase_src: assert property (run
    && cnt_r == (ctrl_r[lepwm_pkg::CTRL_PHF] ? filter_duty : regs_r[8])
    |=> phase_trig_r) else $error("phase trigger missed");
  a_smp1_fix: assert property (run && cnt_r == regs_r[9] |=> smp1_trig_r)
    else $error("sample trigger one missed");
  c_a_pulse: cover property (!pwm_a_r ##1 pwm_a_r ##[1:300] !pwm_a_r);
  c_wrap: cover property (run && cnt_r == regs_r[1] ##1 cnt_r == lepwm_pkg::CNT_ZERO);
  c_mid: cover property (ctrl_r[lepwm_pkg::CTRL_MID] && adapt_trig_r);
endmodule : lepwm_top
`default_nettype wire

// >>> verification/lepwm_gate_model.sv
// Gate driver model: high-side and low-side inputs of one bridge leg
`timescale 1ns/1ps
`default_nettype none
module lepwm_gate_model
(
  input  wire logic aclk,
  input  wire logic gate_hi,
  input  wire logic gate_lo,
  output var  int   overlap_cnt
);
  int ov_cnt = 0;
  // Both switches on at once shorts the rail, so every such cycle is counted
  always @(posedge aclk)
  begin
    if (gate_hi === 1'b1 && gate_lo === 1'b1)
      ov_cnt <= ov_cnt + 1;
  end
  assign overlap_cnt = ov_cnt;
endmodule : lepwm_gate_model
`default_nettype wire

// >>> verification/leading_edge_pwm_event_timing_tb.sv
// Testbench: leading-edge PWM edge and trigger placement over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module leading_edge_pwm_event_timing_tb;
  // ****************************************
  // Signals, table and helpers
  // ****************************************
  typedef struct { int duty; bit mid; bit phf; int a_rise; int adapt; int phase; } lepwm_row_t;
  logic        aclk;
  logic        aresetn;
  logic [15:0] filter_duty;
  logic [5:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  outs;
  logic [7:0]  prev_o = '0;
  int          err_total, n_checks, overlaps, t_s1_prev;
  int          cyc = 0;
  int          tr [8];
  int          tf [8];
  // Period 99, event1 80, dead time ev2-ev3 = 4, sample1 at 10 is the timing reference
  logic [5:0]  cfg_a [14] = '{lepwm_pkg::A_PERIOD, lepwm_pkg::A_EV1, lepwm_pkg::A_EV2,
    lepwm_pkg::A_EV3, lepwm_pkg::A_EV4, lepwm_pkg::A_CADJ, lepwm_pkg::A_ADS, lepwm_pkg::A_PHASE,
    lepwm_pkg::A_SMP1, lepwm_pkg::A_SMP2, lepwm_pkg::A_BLKAB, lepwm_pkg::A_BLKAE,
    lepwm_pkg::A_BLKBB, lepwm_pkg::A_BLKBE};
  logic [31:0] cfg_d [14] = '{32'h63, 32'h50, 32'h7, 32'h3, 32'h5, 32'h2, 32'h5, 32'h1E,
    32'h0A, 32'h5A, 32'h0C, 32'h14, 32'h32, 32'h38};
  // Inputs (duty, mid-pulse, phase from duty) beside expected A rise, adaptive and phase slots
  lepwm_row_t  rows [4] = '{'{20, 1'b0, 1'b0, 62, 65, 30}, '{40, 1'b1, 1'b1, 42, 65, 40},
    '{61, 1'b1, 1'b0, 21, 55, 30}, '{61, 1'b0, 1'b1, 21, 24, 61}};

  lepwm_top lepwm_top_inst (.aclk(aclk), .aresetn(aresetn), .filter_duty(filter_duty),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_a_r(outs[0]), .pwm_b_r(outs[1]), .adapt_trig_r(outs[2]), .phase_trig_r(outs[3]),
    .smp2_trig_r(outs[4]), .blank_a_r(outs[5]), .blank_b_r(outs[6]), .smp1_trig_r(outs[7]));
  lepwm_gate_model lepwm_gate_model_inst (.aclk(aclk), .gate_hi(outs[0]), .gate_lo(outs[1]),
    .overlap_cnt(overlaps));

  // Clock at 125 MHz
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Edge recorder: latest rise and fall cycle of every output
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    prev_o <= outs;
    for (int i = 0; i < 8; i++)
    begin
      if (outs[i] === 1'b1 && prev_o[i] !== 1'b1) tr[i] <= cyc;
      if (outs[i] !== 1'b1 && prev_o[i] === 1'b1) tf[i] <= cyc;
    end
    if (outs[7] === 1'b1 && prev_o[7] !== 1'b1) t_s1_prev <= tr[7];
  end

  task automatic chk_t(input string nm, input int exp, input int got);
    n_checks++;
    if (exp != got)
    begin
      err_total++;
      $display("unexpected %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_t

  task automatic chk_v(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_v

  // Distances are taken from the sample-one pulse, so fixed pipeline delay cancels out
  task automatic chk_ev(input string nm, input int i, input bit rise, input int tgt,
                        input int lvl);
    int t;
    t = rise ? tr[i] : tf[i];
    chk_t(nm, (tgt - 10 + lvl + 200) % 100, ((t - tr[7]) % 100 + 100) % 100);
  endtask : chk_ev

  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Watchdog: the full sequence needs about 1250 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int d;
    int ar;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    filter_duty = 16'h0000;
    wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_v("outputs after reset", 32'h0, {24'h0, outs});
    axi_rd(lepwm_pkg::A_PERIOD, rd, resp);
    chk_v("period reset", 32'h00FF, rd);
    axi_wr(6'h02, 32'h1, resp);
    chk_v("unaligned write resp", {30'h0, lepwm_pkg::RESP_SLVERR}, {30'h0, resp});
    axi_wr(lepwm_pkg::A_STAT, 32'h1234, resp);
    chk_v("status write resp", {30'h0, lepwm_pkg::RESP_SLVERR}, {30'h0, resp});
    axi_rd(lepwm_pkg::A_STAT, rd, resp);
    chk_v("idle counter", 32'h0, rd);
    axi_rd(6'h05, rd, resp);
    chk_v("unaligned read resp", {30'h0, lepwm_pkg::RESP_SLVERR}, {30'h0, resp});
    chk_v("unaligned read data", 32'h0, rd);
    // Configuration rows, each read back
    for (int k = 0; k < 14; k++)
    begin
      axi_wr(cfg_a[k], cfg_d[k], resp);
      axi_rd(cfg_a[k], rd, resp);
      chk_v("register readback", cfg_d[k], rd);
    end
    // Ordinary cases: duty and mode table
    foreach (rows[n])
    begin
      d = rows[n].duty;
      axi_wr(lepwm_pkg::A_CTRL, {29'h0, rows[n].phf, rows[n].mid, 1'b1}, resp);
      filter_duty <= d[15:0];
      repeat (250) @(posedge aclk);
      ar = rows[n].a_rise;
      chk_t("period length", 100, tr[7] - t_s1_prev);
      chk_ev("a rise", 0, 1, ar, 1);
      chk_ev("a fall", 0, 0, 80, 1);
      chk_ev("b rise", 1, 1, 5, 1);
      chk_ev("b fall", 1, 0, ar - 4, 1);
      chk_ev("adaptive", 2, 1, rows[n].adapt, 0);
      chk_ev("phase", 3, 1, rows[n].phase, 0);
      chk_ev("sample two", 4, 1, 90, 0);
      chk_ev("blank a begin", 5, 1, 12, 1);
      chk_ev("blank a end", 5, 0, 20, 1);
      chk_ev("blank b begin", 6, 1, 50, 1);
      chk_ev("blank b end", 6, 0, 56, 1);
    end
    // Disabled: everything low and the counter parked at zero
    axi_wr(lepwm_pkg::A_CTRL, 32'h0, resp);
    repeat (5) @(posedge aclk);
    chk_v("outputs disabled", 32'h0, {24'h0, outs});
    axi_rd(lepwm_pkg::A_STAT, rd, resp);
    chk_v("counter disabled", 32'h0, rd);
    // Byte strobes: only the strobed byte of a register changes
    wstrb <= 4'h2;
    axi_wr(lepwm_pkg::A_PHASE, 32'hABCD_1200, resp);
    wstrb <= 4'hF;
    axi_rd(lepwm_pkg::A_PHASE, rd, resp);
    chk_v("strobed write", 32'h0000_121E, rd);
    // Reset in mid-run restores defaults
    axi_wr(lepwm_pkg::A_CTRL, 32'h1, resp);
    repeat (70) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_v("outputs after second reset", 32'h0, {24'h0, outs});
    axi_rd(lepwm_pkg::A_PERIOD, rd, resp);
    chk_v("period after second reset", 32'h00FF, rd);
    axi_rd(lepwm_pkg::A_CTRL, rd, resp);
    chk_v("control after second reset", 32'h0, rd);
    axi_rd(lepwm_pkg::A_STAT, rd, resp);
    chk_v("counter after second reset", 32'h0, rd);
    chk_t("gate overlap cycles", 0, overlaps);
    complete_run();
  end
endmodule : leading_edge_pwm_event_timing_tb
`default_nettype wire
